// ==== adc_port_device.sv ====
// Converter end of the parallel host port: configuration words, sample FIFO,
// block-ready pulse and FIFO readout.
// Assumes link pins are synchronous to mclk; analog inputs arrive as codes.
//
// Contract
// - Block ready shown by active-low pulse.
// - Block size equals programmed trigger level.
// - Single input offers levels 1,4,8,14.
// - Host reads trigger-level samples per pulse.
// - Read is chip selects and read strobe.
// - Two ten-bit configuration registers.
// - Lines 9:0 value, 11:10 address.
// - Address 0 first, 1 second, rest reserved.
// - Bit 0 picks internal/external reference.
// - Continuous mode converts each clock falling edge.
// - Single mode: falling edge starts conversion.
// - Single mode ready only at trigger.
// - Power down stops conversion, port works.
// - Bits 3,4 select the input.
// - Bits 5,6 count differential channels.
// - Bit 7 enables autoscan.
// - Bits 8,9 select test voltages.
// - Second register field layout.
// - Trigger when written count reaches level.
// - Soft reset clears all, five-cycle holdoff.
// - Selection codes pick inputs and autoscan.
`timescale 1ns/1ps
module adc_port_device (
  adc_port_if.device link,
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] analogInPos,
  input wire logic [11:0] analogInNeg,
  output logic refSelExternal,
  output logic powerDown
);

  typedef enum logic {CONV_IDLE = 1'b0, CONV_SECOND = 1'b1} conv_e;

  logic [9:0] setupWord, next_setupWord;
  logic [9:0] fifoSetupWord, next_fifoSetupWord;
  logic [11:0] fifoMem [adc_port_pkg::FIFO_DEPTH];
  logic [3:0] wrPtr, next_wrPtr;
  logic [3:0] rdPtr, next_rdPtr;
  logic [4:0] fill, next_fill;
  logic [4:0] trigCount, next_trigCount;
  logic readyN, next_readyN;
  logic [11:0] dataOut, next_dataOut;
  logic convPrev, readPrev, writePrev;
  logic scanNeg, next_scanNeg;
  conv_e convState, next_convState;
  logic [11:0] heldNeg, next_heldNeg;
  logic [2:0] holdoff, next_holdoff;

  logic readQual, writeQual, readStart, writeStart, convFall;
  logic twoInputs, canConvert, push, pop, softReset, fifoClear;
  logic [4:0] inputSel;
  logic [1:0] checkSel;
  logic [1:0] regAddr;
  logic [11:0] raw, pushData;
  logic [4:0] level;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  assign readQual = ~link.chipSelectLowN & link.chipSelectHigh & ~link.readStrobeN;
  assign writeQual = ~link.chipSelectLowN & link.chipSelectHigh & ~link.writeStrobeN;
  assign readStart = readQual & ~readPrev;
  assign writeStart = writeQual & ~writePrev;
  assign convFall = convPrev & ~link.conversionClockIn;
  assign regAddr = link.dataBus[adc_port_pkg::ADDR_LSB +: 2];

  assign inputSel = setupWord[adc_port_pkg::INPUT_SEL_LSB +: 5];
  assign checkSel = setupWord[adc_port_pkg::CHECK_SEL_LSB +: 2];
  assign twoInputs = (inputSel == adc_port_pkg::SEL_SCAN);
  assign canConvert = ~setupWord[adc_port_pkg::POWER_DOWN_BIT] && (holdoff == 3'h0);
  assign level = adc_port_pkg::trigger_level(fifoSetupWord[adc_port_pkg::LEVEL_SEL_LSB +: 2], twoInputs);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_setupWord = setupWord;
    next_fifoSetupWord = fifoSetupWord;
    next_convState = convState;
    next_heldNeg = heldNeg;
    next_scanNeg = scanNeg;
    next_holdoff = (holdoff != 3'h0) ? holdoff - 3'h1 : holdoff;
    softReset = 1'b0;
    fifoClear = 1'b0;
    push = 1'b0;
    raw = analogInPos;

    // Configuration writes; addresses with the high bit set are ignored.
    if (writeStart) begin
      case (regAddr)
        adc_port_pkg::ADDR_SETUP: begin
          next_setupWord = link.dataBus[9:0];
        end
        adc_port_pkg::ADDR_FIFO_SETUP: begin
          softReset = link.dataBus[adc_port_pkg::SOFT_RESET_BIT];
          fifoClear = link.dataBus[adc_port_pkg::FIFO_CLEAR_BIT];
          // Command bits are strobes and are stored as zero.
          next_fifoSetupWord = link.dataBus[9:0] & 10'h3fc;
        end
        default: begin
        end
      endcase
    end

    // Sample generation: the held second input completes first unless a soft reset or FIFO clear drops it.
    if (convState == CONV_SECOND) begin
      push = 1'b1;
      raw = heldNeg;
      next_convState = CONV_IDLE;
    end else if (convFall && canConvert) begin
      push = 1'b1;
      if (setupWord[adc_port_pkg::MODE_BIT]) begin
        // Both inputs are held on the same edge and written back to back.
        raw = (inputSel == adc_port_pkg::SEL_NEG) ? analogInNeg : analogInPos;
        if (twoInputs) begin
          next_heldNeg = analogInNeg;
          next_convState = CONV_SECOND;
        end
      end else begin
        if (twoInputs) begin
          raw = scanNeg ? analogInNeg : analogInPos;
          next_scanNeg = ~scanNeg;
        end else begin
          raw = (inputSel == adc_port_pkg::SEL_NEG) ? analogInNeg : analogInPos;
        end
      end
    end

    if (softReset) begin
      next_setupWord = adc_port_pkg::SETUP_RESET;
      next_fifoSetupWord = adc_port_pkg::FIFO_SETUP_RESET;
      next_convState = CONV_IDLE;
      next_scanNeg = 1'b0;
      next_holdoff = adc_port_pkg::SOFT_RESET_CYCLES;
      push = 1'b0;
    end
  end

  // Test voltages replace the input; format flips the sign bit.
  always_comb begin
    case (checkSel)
      2'h1: pushData = adc_port_pkg::CHECK_HIGH;
      2'h2: pushData = adc_port_pkg::CHECK_MID;
      2'h3: pushData = adc_port_pkg::CHECK_LOW;
      default: pushData = raw;
    endcase
    if (fifoSetupWord[adc_port_pkg::FORMAT_BIT]) begin
      pushData[11] = ~pushData[11];
    end
  end

  // ----------------------------------------------------------------------
  // FIFO pointers, trigger and readout
  // ----------------------------------------------------------------------
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_fill = fill;
    next_trigCount = trigCount;
    next_readyN = 1'b1;
    next_dataOut = dataOut;
    pop = readStart && (fill != 5'h00);

    if (readStart) begin
      next_dataOut = (fill != 5'h00) ? fifoMem[rdPtr] : 12'h000;
    end
    if (pop) begin
      next_rdPtr = rdPtr + 4'h1;
    end
    if (push) begin
      next_wrPtr = wrPtr + 4'h1;
      // A full buffer overwrites its oldest entry.
      if (fill == 5'h10 && !pop) begin
        next_rdPtr = rdPtr + 4'h1;
      end
      if (trigCount + 5'h01 >= level) begin
        next_trigCount = 5'h00;
        next_readyN = 1'b0;
      end else begin
        next_trigCount = trigCount + 5'h01;
      end
    end
    case ({push, pop})
      2'b10: next_fill = (fill == 5'h10) ? fill : fill + 5'h01;
      2'b01: next_fill = fill - 5'h01;
      default: next_fill = fill;
    endcase
    if (softReset || fifoClear) begin
      next_wrPtr = 4'h0;
      next_rdPtr = 4'h0;
      next_fill = 5'h00;
      next_trigCount = 5'h00;
      next_readyN = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      setupWord <= adc_port_pkg::SETUP_RESET;
      fifoSetupWord <= adc_port_pkg::FIFO_SETUP_RESET;
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      fill <= 5'h00;
      trigCount <= 5'h00;
      readyN <= 1'b1;
      dataOut <= 12'h000;
      convPrev <= 1'b1;
      readPrev <= 1'b0;
      writePrev <= 1'b0;
      scanNeg <= 1'b0;
      convState <= CONV_IDLE;
      heldNeg <= 12'h000;
      holdoff <= 3'h0;
    end else begin
      setupWord <= next_setupWord;
      fifoSetupWord <= next_fifoSetupWord;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fill <= next_fill;
      trigCount <= next_trigCount;
      readyN <= next_readyN;
      dataOut <= next_dataOut;
      convPrev <= link.conversionClockIn;
      readPrev <= readQual;
      writePrev <= writeQual;
      scanNeg <= next_scanNeg;
      convState <= next_convState;
      heldNeg <= next_heldNeg;
      holdoff <= next_holdoff;
    end
  end

  // Storage has no reset; pointers and fill count define what is valid.
  always_ff @(posedge mclk) begin
    if (push && !softReset && !fifoClear) begin
      fifoMem[wrPtr] <= pushData;
    end
  end

  assign link.devData = dataOut;
  assign link.devDataOe = readQual;
  assign link.sampleBlockReadyN = readyN;
  assign refSelExternal = setupWord[adc_port_pkg::REF_SEL_BIT];
  assign powerDown = setupWord[adc_port_pkg::POWER_DOWN_BIT];

endmodule // adc_port_device

// ==== adc_port_pkg.sv ====
// Shared constants for the converter host port: configuration word layout,
// reset values, trigger levels and host-side register map.
// Assumes a single 125 MHz clock shared by both ends of the link.
package adc_port_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int CFG_W = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;

  // ----------------------------------------------------------------------
  // Configuration word addressing, carried on data lines 11:10
  // ----------------------------------------------------------------------
  localparam int ADDR_LSB = 10;
  localparam logic [1:0] ADDR_SETUP = 2'h0;
  localparam logic [1:0] ADDR_FIFO_SETUP = 2'h1;

  // ----------------------------------------------------------------------
  // Converter setup word fields
  // ----------------------------------------------------------------------
  localparam int REF_SEL_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int POWER_DOWN_BIT = 2;
  localparam int INPUT_SEL_LSB = 3;
  localparam int CHECK_SEL_LSB = 8;
  localparam logic [4:0] SEL_POS = 5'h00;
  localparam logic [4:0] SEL_NEG = 5'h01;
  localparam logic [4:0] SEL_DIFF = 5'h04;
  localparam logic [4:0] SEL_SCAN = 5'h11;
  localparam logic [9:0] SETUP_RESET = 10'h020;

  // ----------------------------------------------------------------------
  // FIFO and output setup word fields
  // ----------------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 0;
  localparam int FIFO_CLEAR_BIT = 1;
  localparam int LEVEL_SEL_LSB = 2;
  localparam int OUT_TRISTATE_BIT = 4;
  localparam int OUT_POLARITY_BIT = 5;
  localparam int PIN_DIR_BIT = 6;
  localparam int FORMAT_BIT = 7;
  localparam int OFFSET_BIT = 8;
  localparam int READBACK_BIT = 9;
  localparam logic [9:0] FIFO_SETUP_RESET = 10'h000;

  // ----------------------------------------------------------------------
  // Test voltages and timing
  // ----------------------------------------------------------------------
  localparam logic [11:0] CHECK_HIGH = 12'hfff;
  localparam logic [11:0] CHECK_MID = 12'h800;
  localparam logic [11:0] CHECK_LOW = 12'h000;
  localparam logic [2:0] SOFT_RESET_CYCLES = 3'h5;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_HALF_NS = 64;
  localparam logic [3:0] CONV_HALF_CYCLES = 4'(CONV_HALF_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Host register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_CONV_OFS = 8'h04;
  localparam logic [7:0] HOST_BLOCK_OFS = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h0c;
  localparam logic [7:0] HOST_SAMPLE_OFS = 8'h10;
  localparam logic [4:0] HOST_BLOCK_RESET = 5'h01;

  // Block size for a level selection; two-input autoscan keeps blocks even.
  function automatic logic [4:0] trigger_level(input logic [1:0] sel, input logic twoInputs);
    case (sel)
      2'h0: trigger_level = twoInputs ? 5'h02 : 5'h01;
      2'h1: trigger_level = 5'h04;
      2'h2: trigger_level = 5'h08;
      default: trigger_level = twoInputs ? 5'h0c : 5'h0e;
    endcase
  endfunction

endpackage

// ==== adc_port_if.sv ====
// Parallel link between the converter's host port and its controller.
// The shared data bus is resolved here from the two output enables.
`timescale 1ns/1ps
interface adc_port_if;
  logic chipSelectLowN;
  logic chipSelectHigh;
  logic readStrobeN;
  logic writeStrobeN;
  logic [11:0] hostData;
  logic hostDataOe;
  logic [11:0] devData;
  logic devDataOe;
  logic [11:0] dataBus;
  logic conversionClockIn;
  logic sampleBlockReadyN;

  // The device wins a clash; an undriven bus reads as zero.
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 12'h000);

  modport device(
    input chipSelectLowN,
    input chipSelectHigh,
    input readStrobeN,
    input writeStrobeN,
    input dataBus,
    input conversionClockIn,
    output devData,
    output devDataOe,
    output sampleBlockReadyN
  );

  modport host(
    output chipSelectLowN,
    output chipSelectHigh,
    output readStrobeN,
    output writeStrobeN,
    output hostData,
    output hostDataOe,
    output conversionClockIn,
    input dataBus,
    input sampleBlockReadyN
  );
endinterface // adc_port_if

// ==== adc_port_host.sv ====
// Controller end of the converter port: drives configuration writes,
// the conversion clock, and fetches each ready block into a local buffer.
// Assumes software polls the busy flag before issuing a configuration word.
`timescale 1ns/1ps
module adc_port_host (
  adc_port_if.host link,
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regReadData
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_STROBE = 2'b01,
    BUS_HOLD = 2'b11,
    BUS_GAP = 2'b10
  } bus_e;

  bus_e busState, next_busState;
  logic isRead, next_isRead;
  logic pending, next_pending;
  logic [11:0] cmdWord, next_cmdWord;
  logic freeRun, next_freeRun;
  logic [4:0] blockLen, next_blockLen;
  logic [5:0] readsLeft, next_readsLeft;
  logic [11:0] buffer [adc_port_pkg::FIFO_DEPTH];
  logic [3:0] bufWr, next_bufWr;
  logic [3:0] bufRd, next_bufRd;
  logic [4:0] bufFill, next_bufFill;
  logic [3:0] divCount, next_divCount;
  logic [3:0] startCount, next_startCount;
  logic convLevel, next_convLevel, toggleLevel, next_toggleLevel;
  logic readyPrev;
  logic [31:0] next_regReadData;
  logic capture, swPop, readyPulse;

  assign readyPulse = readyPrev & ~link.sampleBlockReadyN;
  assign capture = (busState == BUS_HOLD) && isRead;
  assign swPop = regRead && (regAddr == adc_port_pkg::HOST_SAMPLE_OFS) && (bufFill != 5'h00);

  // ----------------------------------------------------------------------
  // Access sequencer and software registers
  // ----------------------------------------------------------------------
  always_comb begin
    next_busState = busState;
    next_isRead = isRead;
    next_pending = pending;
    next_cmdWord = cmdWord;
    next_freeRun = freeRun;
    next_blockLen = blockLen;
    next_readsLeft = readsLeft;
    next_regReadData = 32'h0;

    if (regWrite) begin
      case (regAddr)
        adc_port_pkg::HOST_CMD_OFS: begin
          // A word written while one is outstanding is dropped.
          if (!pending) begin
            next_cmdWord = regWriteData[11:0];
            next_pending = 1'b1;
          end
        end
        adc_port_pkg::HOST_CONV_OFS: next_freeRun = regWriteData[0];
        adc_port_pkg::HOST_BLOCK_OFS: next_blockLen = regWriteData[4:0];
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        adc_port_pkg::HOST_CMD_OFS: next_regReadData = {20'h0, cmdWord};
        adc_port_pkg::HOST_CONV_OFS: next_regReadData = {31'h0, freeRun};
        adc_port_pkg::HOST_BLOCK_OFS: next_regReadData = {27'h0, blockLen};
        adc_port_pkg::HOST_STATUS_OFS: next_regReadData = {14'h0, readsLeft, 3'h0, bufFill, 3'h0, pending};
        adc_port_pkg::HOST_SAMPLE_OFS: next_regReadData = {20'h0, (bufFill != 5'h00) ? buffer[bufRd] : 12'h000};
        default: next_regReadData = 32'h0;
      endcase
    end

    if (readyPulse) begin
      next_readsLeft = readsLeft + {1'b0, blockLen};
    end

    case (busState)
      BUS_IDLE: begin
        // Block fetches go first; a full buffer stalls them.
        if (readsLeft != 6'h00 && bufFill != 5'h10) begin
          next_isRead = 1'b1;
          next_busState = BUS_STROBE;
        end else if (pending) begin
          next_isRead = 1'b0;
          next_busState = BUS_STROBE;
        end
      end
      BUS_STROBE: next_busState = BUS_HOLD;
      BUS_HOLD: begin
        next_busState = BUS_GAP;
        if (isRead) begin
          next_readsLeft = next_readsLeft - 6'h01;
        end else begin
          next_pending = 1'b0;
        end
      end
      BUS_GAP: next_busState = BUS_IDLE;
      default: next_busState = BUS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Local buffer and conversion clock
  // ----------------------------------------------------------------------
  always_comb begin
    next_bufWr = capture ? bufWr + 4'h1 : bufWr;
    next_bufRd = swPop ? bufRd + 4'h1 : bufRd;
    case ({capture, swPop})
      2'b10: next_bufFill = bufFill + 5'h01;
      2'b01: next_bufFill = bufFill - 5'h01;
      default: next_bufFill = bufFill;
    endcase

    next_divCount = (divCount == adc_port_pkg::CONV_HALF_CYCLES - 4'h1) ? 4'h0 : divCount + 4'h1;
    next_toggleLevel = (divCount == adc_port_pkg::CONV_HALF_CYCLES - 4'h1) ? ~toggleLevel : toggleLevel;
    next_startCount = (startCount != 4'h0) ? startCount - 4'h1 : startCount;
    // Writing 1 to bit 1 with bit 0 clear gives one low start pulse of a half period.
    if (regWrite && regAddr == adc_port_pkg::HOST_CONV_OFS && regWriteData[1]) begin
      next_startCount = adc_port_pkg::CONV_HALF_CYCLES;
    end
    next_convLevel = freeRun ? toggleLevel : (startCount == 4'h0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busState <= BUS_IDLE;
      isRead <= 1'b0;
      pending <= 1'b0;
      cmdWord <= 12'h000;
      freeRun <= 1'b0;
      blockLen <= adc_port_pkg::HOST_BLOCK_RESET;
      readsLeft <= 6'h00;
      bufWr <= 4'h0;
      bufRd <= 4'h0;
      bufFill <= 5'h00;
      divCount <= 4'h0;
      startCount <= 4'h0;
      toggleLevel <= 1'b1;
      convLevel <= 1'b1;
      readyPrev <= 1'b1;
      regReadData <= 32'h0;
    end else begin
      busState <= next_busState;
      isRead <= next_isRead;
      pending <= next_pending;
      cmdWord <= next_cmdWord;
      freeRun <= next_freeRun;
      blockLen <= next_blockLen;
      readsLeft <= next_readsLeft;
      bufWr <= next_bufWr;
      bufRd <= next_bufRd;
      bufFill <= next_bufFill;
      divCount <= next_divCount;
      startCount <= next_startCount;
      toggleLevel <= next_toggleLevel;
      convLevel <= next_convLevel;
      readyPrev <= link.sampleBlockReadyN;
      regReadData <= next_regReadData;
    end
  end

  always_ff @(posedge mclk) begin
    if (capture) begin
      buffer[bufWr] <= link.dataBus;
    end
  end

  // Chip selects follow the strobe so every access is cleanly framed.
  assign link.chipSelectLowN = ~((busState == BUS_STROBE) || (busState == BUS_HOLD));
  assign link.chipSelectHigh = (busState == BUS_STROBE) || (busState == BUS_HOLD);
  assign link.readStrobeN = ~(((busState == BUS_STROBE) || (busState == BUS_HOLD)) && isRead);
  assign link.writeStrobeN = ~(((busState == BUS_STROBE) || (busState == BUS_HOLD)) && !isRead);
  assign link.hostData = cmdWord;
  assign link.hostDataOe = ((busState == BUS_STROBE) || (busState == BUS_HOLD)) && !isRead;
  assign link.conversionClockIn = convLevel;

endmodule // adc_port_host

// ==== adc_port_properties.sv ====
// Concurrent checks on the link between the host end and the converter end.
// Assumes one mclk domain and a synchronous, active-high rst.
`timescale 1ns/1ps
module adc_port_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chipSelectLowN,
  input wire logic chipSelectHigh,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [11:0] hostData,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic sampleBlockReadyN
);
  // ----------------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_lowTwo(sig);
    !sig [*2] ##1 sig;
  endsequence
  property p_readyPulse; !sampleBlockReadyN |=> sampleBlockReadyN; endproperty
  property p_readQual; devDataOe == (!chipSelectLowN && chipSelectHigh && !readStrobeN); endproperty
  property p_writeLen; $fell(writeStrobeN) |-> s_lowTwo(writeStrobeN); endproperty
  property p_readLen; $fell(readStrobeN) |-> s_lowTwo(readStrobeN); endproperty
  property p_writeSel; !writeStrobeN |-> !chipSelectLowN && chipSelectHigh && hostDataOe && readStrobeN; endproperty
  property p_writeData; !writeStrobeN && !$fell(writeStrobeN) |-> $stable(hostData); endproperty
  property p_gap; $rose(readStrobeN) || $rose(writeStrobeN) |-> readStrobeN && writeStrobeN; endproperty
  property p_hostDrive; hostDataOe |-> !writeStrobeN; endproperty
  property p_noClash; !(hostDataOe && devDataOe); endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("ready low longer than one cycle");
  a_readQual: assert property (p_readQual) else $error("read drive not tied to selects");
  a_writeLen: assert property (p_writeLen) else $error("write strobe length wrong");
  a_readLen: assert property (p_readLen) else $error("read strobe length wrong");
  a_writeSel: assert property (p_writeSel) else $error("write without selects");
  a_writeData: assert property (p_writeData) else $error("word changed during write");
  a_gap: assert property (p_gap) else $error("no idle cycle between accesses");
  a_hostDrive: assert property (p_hostDrive) else $error("host drives bus outside write");
  a_noClash: assert property (p_noClash) else $error("both ends drive bus");
endmodule // adc_port_properties

// ==== test_adc_host_port_and_config.sv ====
// Self-checking bench joining the host end and the converter end.
// Assumes software port and analog codes are the only stimulus.
`timescale 1ns/1ps
module test_adc_host_port_and_config;
  // ----------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWriteData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regReadData;
  logic [11:0] analogInPos = 12'h3a5;
  logic [11:0] analogInNeg = 12'h5c3;
  logic refSelExternal;
  logic powerDown;
  int errTotal = 0;
  int nCompared = 0;
  int nPulse = 0;
  localparam int TSTS [8] = '{0, 0, 0, 0, 1, 2, 3, 0};
  localparam int SELS [8] = '{0, 1, 4, 17, 0, 0, 0, 17};
  localparam int LSEL [8] = '{0, 1, 2, 3, 3, 0, 1, 0};
  localparam int LVLS [8] = '{1, 4, 8, 12, 14, 1, 4, 2};
  adc_port_if link ();
  adc_port_device u_adc_port_device (.link(link.device), .mclk(mclk), .rst(rst), .analogInPos(analogInPos),
    .analogInNeg(analogInNeg), .refSelExternal(refSelExternal), .powerDown(powerDown));
  adc_port_host u_adc_port_host (.link(link.host), .mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData));
  adc_port_properties u_adc_port_properties (.mclk(mclk), .rst(rst), .chipSelectLowN(link.chipSelectLowN),
    .chipSelectHigh(link.chipSelectHigh), .readStrobeN(link.readStrobeN), .writeStrobeN(link.writeStrobeN),
    .hostData(link.hostData), .hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe),
    .sampleBlockReadyN(link.sampleBlockReadyN));
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (link.sampleBlockReadyN === 1'b0) nPulse <= nPulse + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      errTotal++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic reportAndStop();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic timeOut();
    errTotal++;
    reportAndStop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask
  // Software must not queue a word while the previous one is still pending.
  task automatic cmd(input logic [11:0] w);
    logic [31:0] d;
    wr(adc_port_pkg::HOST_CMD_OFS, {20'h0, w});
    for (int n = 0; n < 20; n++) begin
      rd(adc_port_pkg::HOST_STATUS_OFS, d);
      if (d[0] === 1'b0) return;
    end
    timeOut();
  endtask
  function automatic logic [11:0] want(input int i, input int k);
    case (TSTS[i])
      1: return adc_port_pkg::CHECK_HIGH;
      2: return adc_port_pkg::CHECK_MID;
      // The only low-voltage entry also sets the output format bit.
      3: return {~adc_port_pkg::CHECK_LOW[11], adc_port_pkg::CHECK_LOW[10:0]};
      default: return (SELS[i] == 1 || (SELS[i] == 17 && k % 2 == 1)) ? analogInNeg : analogInPos;
    endcase
  endfunction
  task automatic testReset();
    logic [31:0] d;
    check(refSelExternal, 1'b0);
    check(powerDown, 1'b0);
    rd(adc_port_pkg::HOST_BLOCK_OFS, d);
    check(d, 32'h1);
    rd(8'h20, d);
    check(d, 32'h0);
  endtask
  task automatic testConfig();
    int p0;
    cmd(12'h005);
    check({refSelExternal, powerDown}, 2'h3);
    p0 = nPulse;
    wr(adc_port_pkg::HOST_CONV_OFS, 32'h1);
    repeat (100) @(posedge mclk);
    wr(adc_port_pkg::HOST_CONV_OFS, 32'h0);
    check(nPulse, p0);
    cmd(12'h800);
    cmd(12'hc00);
    check({refSelExternal, powerDown}, 2'h3);
    cmd(12'h401);
    check({refSelExternal, powerDown}, 2'h0);
  endtask
  // Each entry picks inputs, test voltage and level; the conversion clock is
  // stopped right after the first ready pulse so exactly one block is fetched.
  task automatic testBlocks();
    logic [31:0] d;
    int p0;
    int n;
    for (int i = 0; i < 8; i++) begin
      cmd({2'h1, 2'h0, 1'(i == 6), 3'h0, 2'(LSEL[i]), 2'h2});
      cmd({2'h0, 2'(TSTS[i]), 5'(SELS[i]), 1'b0, 1'(i == 7), 1'b0});
      wr(adc_port_pkg::HOST_BLOCK_OFS, LVLS[i]);
      p0 = nPulse;
      wr(adc_port_pkg::HOST_CONV_OFS, (i == 7) ? 32'h2 : 32'h1);
      for (n = 0; n < 600 && nPulse == p0; n++) @(posedge mclk);
      if (nPulse == p0) timeOut();
      wr(adc_port_pkg::HOST_CONV_OFS, 32'h0);
      for (n = 0; n < 60; n++) begin
        rd(adc_port_pkg::HOST_STATUS_OFS, d);
        if (d[8:4] === 5'(LVLS[i])) break;
      end
      check(d[8:4], 5'(LVLS[i]));
      for (int k = 0; k < LVLS[i]; k++) begin
        rd(adc_port_pkg::HOST_SAMPLE_OFS, d);
        check(d[11:0], want(i, k));
      end
      check(nPulse - p0, 1);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    testConfig();
    testBlocks();
    reportAndStop();
  end
endmodule // test_adc_host_port_and_config
